// >>> bench/mrr_top_asserts.sv
/*
  Checker for the magnitude reference bank, bound to mrr_top.
  Assumes the bench keeps the mode register quiet while a load is under way.
*/
`include "mrr_regs.vh"

module mrr_checker (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_q,
  // Sensor core
  input wire [13:0] sample_x,
  input wire sample_valid,
  input wire [1:0] full_scale_range_select,
  input wire detect_trigger,
  // References
  input wire [13:0] ref_x,
  input wire [1:0] ref_range_q,
  input wire ref_active_q
);
  reg [7:0] cfg_c;
  reg [13:0] sh_x;
  reg [13:0] smp_x;
  wire cfg_wr = reg_wr && reg_addr == `MRR_OFS_CFG;
  wire [2:0] md = cfg_c[5:3];

  // Only the X axis is shadowed here; the bench model covers Y and Z.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_c <= 8'h00;
      sh_x <= 14'h0000;
      smp_x <= 14'h0000;
    end else begin
      if (cfg_wr) cfg_c <= reg_wdata;
      if (reg_wr && reg_addr == `MRR_OFS_X_HI) sh_x[13:8] <= reg_wdata[5:0];
      if (reg_wr && reg_addr == `MRR_OFS_X_LO) sh_x[7:0] <= reg_wdata;
      if (sample_valid) smp_x <= sample_x;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_range_follow: assert property (
    ref_range_q == $past(full_scale_range_select)) else $error("range copy wrong");
  a_hi_pad: assert property (
    $past(reg_rd) && $past(reg_addr[0]) && $past(reg_addr) inside {[8'h63:8'h68]}
    |-> reg_rdata_q[7:6] == 2'h0) else $error("high byte pad bits set");
  a_x_readback: assert property (
    $past(reg_rd) && $past(reg_addr) == `MRR_OFS_X_LO |-> reg_rdata_q == sh_x[7:0])
    else $error("x low byte read wrong");
  a_load_regs: assert property (
    cfg_wr && reg_wdata[5] && reg_wdata[3] && !cfg_c[3] |-> ##2 ref_x == sh_x && ref_active_q)
    else $error("register load wrong");
  a_load_live: assert property (
    cfg_wr && !reg_wdata[5] && reg_wdata[3] && !cfg_c[3] |-> ##2 ref_x == smp_x)
    else $error("live load wrong");
  a_track_write: assert property (
    reg_wr && reg_addr == `MRR_OFS_X_LO && md == 3'h7 && ref_active_q
    |-> ##2 ref_x[7:0] == $past(reg_wdata, 2)) else $error("tracking missed");
  a_trig_reload: assert property (
    detect_trigger && md[1:0] == 2'h1 && ref_active_q && !sample_valid && !cfg_wr
    |=> ref_x == smp_x) else $error("trigger reload wrong");
  a_hold_disable: assert property (
    cfg_wr && !reg_wdata[3] && cfg_c[3] |=> $stable(ref_x) [*2])
    else $error("disable changed refs");

  c_enable: cover property (cfg_wr && reg_wdata[3]);
  c_trigger: cover property (detect_trigger && ref_active_q);
  c_track: cover property (reg_wr && md == 3'h7);
endmodule // mrr_checker

bind mrr_top mrr_checker i_chk (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata_q, .sample_x, .sample_valid, .full_scale_range_select, .detect_trigger,
  .ref_x, .ref_range_q, .ref_active_q);

// >>> bench/tb_mrr_top.sv
/*
  Self-checking bench for mrr_top with a byte model of the reference bank.
  Assumes the one-cycle register port and the two-cycle reference load of the design.
*/
`include "mrr_regs.vh"

module tb_mrr_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg sample_valid = 1'b0;
  reg detect_trigger = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg [13:0] sample_x = 14'h0000;
  reg [13:0] sample_y = 14'h0000;
  reg [13:0] sample_z = 14'h0000;
  reg [1:0] range_sel = 2'h0;
  reg [7:0] a;
  reg [7:0] mdl [0:6];
  wire [7:0] reg_rdata_q;
  wire [13:0] ref_x;
  wire [13:0] ref_y;
  wire [13:0] ref_z;
  wire [1:0] ref_range_q;
  wire ref_active_q;
  integer error_cnt = 0;
  integer checked = 0;
  integer seed = 44;

  always #12.5 clk_sys = ~clk_sys;

  mrr_top i_dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .sample_x, .sample_y, .sample_z, .sample_valid, .full_scale_range_select(range_sel),
    .detect_trigger, .ref_x, .ref_y, .ref_z, .ref_range_q, .ref_active_q);

  function [13:0] hl(input integer k);
    hl = {mdl[k][5:0], mdl[k + 1]};
  endfunction

  task chk(input [15:0] seen, input [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input [7:0] ad, input [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // The upper two bits of a high byte are dropped, so the model drops them too.
    if (ad > 8'h62 && ad < 8'h69) mdl[ad - 8'h63] = ad[0] ? d & 8'h3F : d;
  endtask

  task rd(input [7:0] ad, input [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q, e);
  endtask

  task cref(input [13:0] x, input [13:0] y, input [13:0] z);
    @(posedge clk_sys);
    detect_trigger <= 1'b0;
    #1 chk(ref_x, x);
    chk(ref_y, y);
    chk(ref_z, z);
    chk(ref_range_q, range_sel);
  endtask

  task smp;
    @(posedge clk_sys);
    sample_x <= 14'($random(seed));
    sample_y <= 14'($random(seed));
    sample_z <= 14'($random(seed));
    range_sel <= 2'($random(seed));
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
  endtask

  task stop_test;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    for (a = 8'h00; a < 8'h07; a++) mdl[a] = 8'h00;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    for (a = 8'h63; a < 8'h6A; a++) rd(a, 8'h00);
    for (a = 8'h63; a < 8'h6A; a++) wr(a, 8'($random(seed)) | 8'hC0);
    for (a = 8'h63; a < 8'h6A; a++) rd(a, mdl[a - 8'h63]);
    smp;
    wr(8'h6A, 8'h28);
    cref(hl(0), hl(2), hl(4));
    chk(ref_active_q, 1'b1);
    wr(8'h6A, 8'h00);
    wr(8'h6A, 8'h38);
    cref(hl(0), hl(2), hl(4));
    rd(8'h6A, 8'h38);
    for (a = 8'h63; a < 8'h69; a++) begin
      wr(a, 8'($random(seed)));
      cref(hl(0), hl(2), hl(4));
    end
    smp;
    @(posedge clk_sys) detect_trigger <= 1'b1;
    cref(hl(0), hl(2), hl(4));
    wr(8'h6A, 8'h00);
    cref(hl(0), hl(2), hl(4));
    chk(ref_active_q, 1'b0);
    wr(8'h6A, 8'h08);
    cref(sample_x, sample_y, sample_z);
    chk(ref_active_q, 1'b1);
    smp;
    @(posedge clk_sys) detect_trigger <= 1'b1;
    cref(sample_x, sample_y, sample_z);
    stop_test;
  end

  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    stop_test;
  end
endmodule // tb_mrr_top

// >>> logic/mrr_axis_ref.v
/*
  One axis of the reference bank: the host-visible high and low bytes and
  the reference word handed to the detector. Assumes the parent decodes
  addresses and issues one-cycle load pulses.
*/
`include "mrr_regs.vh"

module mrr_axis_ref (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Register writes
  input wire wr_hi,
  input wire wr_lo,
  input wire [`MRR_LO_MSB:0] wr_data,
  // Reference control
  input wire load_live,
  input wire load_regs,
  input wire track_regs,
  input wire [`MRR_REF_MSB:0] live_sample,
  // Outputs
  output reg [`MRR_HI_MSB:0] hi_q,
  output reg [`MRR_LO_MSB:0] lo_q,
  output reg [`MRR_REF_MSB:0] ref_q
);

  // Only six bits are kept, so the two spare bits cannot reach the word.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hi_q <= `MRR_RST_HI;
    end else if (wr_hi) begin
      hi_q <= wr_data[`MRR_HI_MSB:0];
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lo_q <= `MRR_RST_BYTE;
    end else if (wr_lo) begin
      lo_q <= wr_data;
    end
  end

  // A live load wins; it never fires in the same cycle as a register load or tracking.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_q <= `MRR_RST_REF;
    end else if (load_live) begin
      ref_q <= live_sample;
    end else if (load_regs || track_regs) begin
      ref_q <= {hi_q, lo_q};
    end
  end

endmodule // mrr_axis_ref

// >>> logic/mrr_regs.vh
/*
  Register map, field positions and reset values of the magnitude reference
  register bank. Assumes an 8-bit register port and one 40 MHz core clock.
*/
`ifndef MRR_REGS_VH
`define MRR_REGS_VH

`define MRR_ADDR_W 8
`define MRR_DATA_W 8
`define MRR_REF_W 14
`define MRR_REF_MSB 13
`define MRR_HI_W 6
`define MRR_HI_MSB 5
`define MRR_LO_MSB 7
`define MRR_FS_W 2
`define MRR_AXES 3

`define MRR_OFS_X_HI 8'h63
`define MRR_OFS_X_LO 8'h64
`define MRR_OFS_Y_HI 8'h65
`define MRR_OFS_Y_LO 8'h66
`define MRR_OFS_Z_HI 8'h67
`define MRR_OFS_Z_LO 8'h68
`define MRR_OFS_CFG 8'h6A
`define MRR_OFS_STAT 8'h6B
`define MRR_OFS_ACT_X_HI 8'h6C
`define MRR_OFS_ACT_X_LO 8'h6D
`define MRR_OFS_ACT_Y_HI 8'h6E
`define MRR_OFS_ACT_Y_LO 8'h6F
`define MRR_OFS_ACT_Z_HI 8'h70
`define MRR_OFS_ACT_Z_LO 8'h71

`define MRR_CFG_EN 3
`define MRR_CFG_UPDM 4
`define MRR_CFG_INITM 5

`define MRR_STAT_ACTIVE 0
`define MRR_STAT_SRC_REGS 1
`define MRR_STAT_SEEN 2
`define MRR_STAT_TRACK 3

`define MRR_RST_BYTE 8'h00
`define MRR_RST_HI 6'h00
`define MRR_RST_REF 14'h0000
`define MRR_RST_FS 2'h0
`define MRR_ZERO_BYTE 8'h00
`define MRR_PAD_HI 2'h0
`define MRR_PAD_STAT 4'h0

`endif

// >>> logic/mrr_top.v
/*
  Magnitude reference register bank: six reference bytes, a mode register,
  a status register and read-back of the references in use. Assumes live
  samples, the sample strobe and the trigger come from logic on clk_sys.
*/
`include "mrr_regs.vh"

module mrr_top (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Register port
  input wire [`MRR_ADDR_W-1:0] reg_addr,
  input wire [`MRR_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`MRR_DATA_W-1:0] reg_rdata_q,
  // Live samples from the sensor core
  input wire [`MRR_REF_MSB:0] sample_x,
  input wire [`MRR_REF_MSB:0] sample_y,
  input wire [`MRR_REF_MSB:0] sample_z,
  input wire sample_valid,
  input wire [`MRR_FS_W-1:0] full_scale_range_select,
  // Detector trigger
  input wire detect_trigger,
  // Reference outputs
  output wire [`MRR_REF_MSB:0] ref_x,
  output wire [`MRR_REF_MSB:0] ref_y,
  output wire [`MRR_REF_MSB:0] ref_z,
  output reg [`MRR_FS_W-1:0] ref_range_q,
  output reg ref_active_q
);

  localparam NAX = `MRR_AXES;
  localparam RW = `MRR_REF_W;

  // Mode register.
  reg en_q;
  reg updm_q;
  reg initm_q;
  reg en_prev_q;

  // Status.
  reg src_regs_q;
  reg seen_q;

  // Latest valid live sample of each axis.
  reg [NAX*RW-1:0] live_q;

  // Per-axis register views.
  wire [NAX*`MRR_HI_W-1:0] hi_all;
  wire [NAX*`MRR_DATA_W-1:0] lo_all;
  wire [NAX*RW-1:0] ref_all;

  // Address decode.
  wire [NAX-1:0] hit_hi;
  wire [NAX-1:0] hit_lo;
  wire hit_cfg;

  // Load control.
  wire enable_edge;
  wire load_regs;
  wire load_live;
  wire track_regs;
  wire upd_live;

  reg [`MRR_DATA_W-1:0] rd_mux;

  assign hit_hi[0] = (reg_addr == `MRR_OFS_X_HI);
  assign hit_hi[1] = (reg_addr == `MRR_OFS_Y_HI);
  assign hit_hi[2] = (reg_addr == `MRR_OFS_Z_HI);
  assign hit_lo[0] = (reg_addr == `MRR_OFS_X_LO);
  assign hit_lo[1] = (reg_addr == `MRR_OFS_Y_LO);
  assign hit_lo[2] = (reg_addr == `MRR_OFS_Z_LO);
  assign hit_cfg = (reg_addr == `MRR_OFS_CFG);

  // Mode register: only the three mode bits exist, the rest read zero.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en_q <= 1'b0;
      updm_q <= 1'b0;
      initm_q <= 1'b0;
    end else if (reg_wr && hit_cfg) begin
      en_q <= reg_wdata[`MRR_CFG_EN];
      updm_q <= reg_wdata[`MRR_CFG_UPDM];
      initm_q <= reg_wdata[`MRR_CFG_INITM];
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_q;
    end
  end

  // The reference is first loaded on the cycle the function turns on; triggers or tracking reload it later.
  assign enable_edge = en_q && !en_prev_q;
  assign load_regs = enable_edge && initm_q;
  assign upd_live = en_prev_q && en_q && !updm_q && detect_trigger;
  assign load_live = (enable_edge && !initm_q) || upd_live;
  assign track_regs = en_q && en_prev_q && initm_q && updm_q;

  // Hold the newest valid sample so an enable between strobes still has
  // the current output data to capture.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      live_q <= {NAX{`MRR_RST_REF}};
      seen_q <= 1'b0;
    end else if (sample_valid) begin
      live_q <= {sample_z, sample_y, sample_x};
      seen_q <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NAX; g = g + 1) begin : g_axis
      mrr_axis_ref u_axis (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wr_hi(reg_wr && hit_hi[g]),
        .wr_lo(reg_wr && hit_lo[g]),
        .wr_data(reg_wdata),
        .load_live(load_live),
        .load_regs(load_regs),
        .track_regs(track_regs),
        .live_sample(live_q[g*RW +: RW]),
        .hi_q(hi_all[g*`MRR_HI_W +: `MRR_HI_W]),
        .lo_q(lo_all[g*`MRR_DATA_W +: `MRR_DATA_W]),
        .ref_q(ref_all[g*RW +: RW])
      );
    end
  endgenerate

  // The Z pair sits in the same generate loop as X and Y.
  assign ref_x = ref_all[0*RW +: RW];
  assign ref_y = ref_all[1*RW +: RW];
  assign ref_z = ref_all[2*RW +: RW];

  // Source of the active reference, for status.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      src_regs_q <= 1'b0;
    end else if (load_regs) begin
      src_regs_q <= 1'b1;
    end else if (load_live) begin
      src_regs_q <= 1'b0;
    end
  end

  // The reference words carry no scale of their own; the range in force is
  // passed beside them so both are read at the same resolution.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_range_q <= `MRR_RST_FS;
    end else begin
      ref_range_q <= full_scale_range_select;
    end
  end

  // Active goes high together with the first loaded reference.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_active_q <= 1'b0;
    end else if (!en_q) begin
      ref_active_q <= 1'b0;
    end else if (enable_edge) begin
      ref_active_q <= 1'b1;
    end
  end

  // Read mux; unmapped addresses read zero.
  always @* begin
    rd_mux = `MRR_ZERO_BYTE;
    case (reg_addr)
      `MRR_OFS_X_HI: rd_mux = {`MRR_PAD_HI, hi_all[0*`MRR_HI_W +: `MRR_HI_W]};
      `MRR_OFS_X_LO: rd_mux = lo_all[0*`MRR_DATA_W +: `MRR_DATA_W];
      `MRR_OFS_Y_HI: rd_mux = {`MRR_PAD_HI, hi_all[1*`MRR_HI_W +: `MRR_HI_W]};
      `MRR_OFS_Y_LO: rd_mux = lo_all[1*`MRR_DATA_W +: `MRR_DATA_W];
      `MRR_OFS_Z_HI: rd_mux = {`MRR_PAD_HI, hi_all[2*`MRR_HI_W +: `MRR_HI_W]};
      `MRR_OFS_Z_LO: rd_mux = lo_all[2*`MRR_DATA_W +: `MRR_DATA_W];
      `MRR_OFS_CFG: begin
        rd_mux[`MRR_CFG_EN] = en_q;
        rd_mux[`MRR_CFG_UPDM] = updm_q;
        rd_mux[`MRR_CFG_INITM] = initm_q;
      end
      `MRR_OFS_STAT: begin
        rd_mux = {`MRR_PAD_STAT, track_regs, seen_q, src_regs_q, ref_active_q};
      end
      `MRR_OFS_ACT_X_HI: rd_mux = {`MRR_PAD_HI, ref_all[0*RW+`MRR_DATA_W +: `MRR_HI_W]};
      `MRR_OFS_ACT_X_LO: rd_mux = ref_all[0*RW +: `MRR_DATA_W];
      `MRR_OFS_ACT_Y_HI: rd_mux = {`MRR_PAD_HI, ref_all[1*RW+`MRR_DATA_W +: `MRR_HI_W]};
      `MRR_OFS_ACT_Y_LO: rd_mux = ref_all[1*RW +: `MRR_DATA_W];
      `MRR_OFS_ACT_Z_HI: rd_mux = {`MRR_PAD_HI, ref_all[2*RW+`MRR_DATA_W +: `MRR_HI_W]};
      `MRR_OFS_ACT_Z_LO: rd_mux = ref_all[2*RW +: `MRR_DATA_W];
      default: rd_mux = `MRR_ZERO_BYTE;
    endcase
  end

  // Read data stand for as many cycles as reg_rd is held and return to zero after.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= `MRR_ZERO_BYTE;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= `MRR_ZERO_BYTE;
    end
  end

endmodule // mrr_top
